// ---- rtl/flash_host_pkg.sv ----
// constants for the parallel flash host controller
package flash_host_pkg;
  // command addresses and data
  localparam logic [16:0] UNLOCK1_ADDR   = 17'h05555;
  localparam logic [16:0] UNLOCK2_ADDR   = 17'h02aaa;
  localparam logic [7:0]  UNLOCK1_DATA   = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
  localparam logic [7:0]  CMD_ID         = 8'h90;
  localparam logic [7:0]  CMD_RESET      = 8'hf0;
  localparam logic [7:0]  CMD_PROGRAM    = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0]  CMD_SECT_ERASE = 8'h30;
  // identification read offsets
  localparam logic [16:0] ID_MAKER_ADDR  = 17'h00000;
  localparam logic [16:0] ID_PART_ADDR   = 17'h00001;
  localparam logic [16:0] ID_PROT_ADDR   = 17'h00002;
  localparam logic [7:0]  PROT_YES       = 8'h01;
  localparam logic [7:0]  PROT_NO        = 8'h00;
  // sector select bit and status error bit
  localparam int          SECT_LSB       = 14;
  localparam int          ERR_BIT        = 5;
  // pin timing, in ns and cycles at 25 MHz
  localparam int          CLK_NS         = 40;
  localparam int          SETUP_NS       = 40;
  localparam int          PULSE_NS       = 80;
  localparam int          ACCESS_NS      = 120;
  localparam logic [3:0]  SETUP_CYC      = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  PULSE_CYC      = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  ACCESS_CYC     = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  // software register offsets
  localparam logic [3:0]  REG_ADDR       = 4'h0;
  localparam logic [3:0]  REG_DATA       = 4'h1;
  localparam logic [3:0]  REG_CMD        = 4'h2;
  localparam logic [3:0]  REG_STATUS     = 4'h3;
  localparam logic [3:0]  REG_RDATA      = 4'h4;
  // software operation codes
  localparam logic [2:0]  OP_READ        = 3'h0;
  localparam logic [2:0]  OP_WRITE       = 3'h1;
  localparam logic [2:0]  OP_PROGRAM     = 3'h2;
  localparam logic [2:0]  OP_CHIP_ERASE  = 3'h3;
  localparam logic [2:0]  OP_SECT_ERASE  = 3'h4;
  localparam logic [2:0]  OP_ID_ENTER    = 3'h5;
  localparam logic [2:0]  OP_RESET       = 3'h6;
  localparam logic [2:0]  OP_ID_HV       = 3'h7;
endpackage

// ---- rtl/flash_bus_cycle.sv ----
// one timed read or write cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle (
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        start_in,
  input  wire logic        write_in,
  input  wire logic [16:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic [7:0]  pin_data_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [7:0]       rdata_out,
  output logic [16:0]      addr_pin_out,
  output logic [7:0]       data_pin_out,
  output logic             data_oe_out,
  output logic             chip_sel_n_out,
  output logic             out_en_n_out,
  output logic             write_n_out
);
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} cy_state_t;
  typedef struct packed {
    cy_state_t   st;
    logic [3:0]  cnt;
    logic        wr;
    logic        done;
    logic [7:0]  rdata;
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic        oe;
    logic        cs_n;
    logic        oen_n;
    logic        we_n;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
  } cy_t;
  cy_t s_reg, s_next;

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  // setup with strobes high, then the strobe pulse, then one idle cycle
  always_comb begin
    s_next = s_reg;
    s_next.done  = 1'b0;
    s_next.sync1 = pin_data_in;
    s_next.sync2 = s_reg.sync1;
    case (s_reg.st)
      CY_IDLE: begin
        if (start_in) begin
          s_next.st    = CY_SETUP;
          s_next.wr    = write_in;
          s_next.addr  = addr_in;
          s_next.wdata = wdata_in;
          s_next.oe    = write_in;
          s_next.cnt   = flash_host_pkg::SETUP_CYC;
        end
      end
      CY_SETUP: begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1) begin
          s_next.st   = CY_PULSE;
          s_next.cs_n = 1'b0;
          // write needs output enable high; read holds write strobe high
          s_next.oen_n = s_reg.wr;
          s_next.we_n  = ~s_reg.wr;
          // pulses far above the glitch filter width
          s_next.cnt = s_reg.wr ? flash_host_pkg::PULSE_CYC : flash_host_pkg::ACCESS_CYC;
        end
      end
      CY_PULSE: begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1) begin
          // data still held while strobes rise, device latches it then
          s_next.st    = CY_HOLD;
          s_next.cs_n  = 1'b1;
          s_next.oen_n = 1'b1;
          s_next.we_n  = 1'b1;
          s_next.rdata = s_reg.sync2;
        end
      end
      CY_HOLD: begin
        s_next.st   = CY_IDLE;
        s_next.oe   = 1'b0;
        s_next.done = 1'b1;
      end
      default: s_next.st = CY_IDLE;
    endcase
    if (sys_rst_in) begin
      s_next = '0;
      s_next.cs_n  = 1'b1;
      s_next.oen_n = 1'b1;
      s_next.we_n  = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    s_reg <= s_next;
  end

  assign busy_out       = (s_reg.st != CY_IDLE);
  assign done_out       = s_reg.done;
  assign rdata_out      = s_reg.rdata;
  assign addr_pin_out   = s_reg.addr;
  assign data_pin_out   = s_reg.wdata;
  assign data_oe_out    = s_reg.oe;
  assign chip_sel_n_out = s_reg.cs_n;
  assign out_en_n_out   = s_reg.oen_n;
  assign write_n_out    = s_reg.we_n;

  // never drive data while the device may drive it
  AST_NO_CONTENTION: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !s_reg.oen_n |-> !s_reg.oe) else $error("data driven during read");
  // write strobe low only with output enable high and chip select low
  AST_WRITE_QUAL: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !s_reg.we_n |-> (s_reg.oen_n && !s_reg.cs_n)) else $error("unqualified write");
  // write strobe stays low for the full pulse width
  AST_PULSE_WIDTH: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(s_reg.we_n) |-> !s_reg.we_n [*2]) else $error("write pulse too short");
  // address and data stand still while the strobe is low
  AST_ADDR_STABLE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (!s_reg.we_n && $past(!s_reg.we_n)) |-> ($stable(s_reg.addr) && $stable(s_reg.wdata)))
    else $error("address moved in pulse");
  // data keeps driving one cycle past the rising strobe
  AST_DATA_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(s_reg.we_n) |-> s_reg.oe) else $error("data released too early");
endmodule

// ---- rtl/flash_host_ctrl.sv ----
// host-side controller for a byte-wide sectored parallel flash
// Summary of operation
// - high-voltage ID: A1..A0 pick maker/part/protect
// - protect check returns 01 or 00
// - ID also readable after command sequence
// - unlock writes precede every program or erase
// - write needs select, strobe low, enable high
// - host resets after error status bit high
// - ID mode left only by reset command
// - ID sequence AA, 55, 90 then reads
// - reset sequence AA, 55, F0
// - program four writes, erase six writes
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module flash_host_ctrl (
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // software port
  input  wire logic [3:0]  sw_addr_in,
  input  wire logic [31:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic      [31:0] sw_rdata_out,
  // flash pins
  input  wire logic [7:0]  data_pins_in,
  output logic      [7:0]  data_pins_out,
  output logic             data_pins_oe_out,
  output logic      [16:0] addr_pins_out,
  output logic             chip_sel_n_out,
  output logic             out_en_n_out,
  output logic             write_n_out,
  output logic             elevated_id_voltage_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_POLL} st_t;
  typedef struct packed {
    st_t         st;
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  op;
    logic [2:0]  step;
    logic [2:0]  last;
    logic        hv;
    logic        id_mode;
    logic        err;
    logic        done;
    logic        pu_block;
    logic [7:0]  rdata;
    logic [7:0]  prev;
    logic [31:0] sw_rdata;
  } ctl_t;
  ctl_t s_reg, s_next;

  logic        cy_start;
  logic        cy_write;
  logic [16:0] cy_addr;
  logic [7:0]  cy_wdata;
  logic        cy_busy;
  logic        cy_done;
  logic [7:0]  cy_rdata;
  logic [16:0] pin_addr;
  logic [7:0]  pin_wdata;
  logic        pin_oe;
  logic        pin_cs_n;
  logic        pin_oen_n;
  logic        pin_we_n;

  // ----------------------------------------
  // command step tables
  // ----------------------------------------
  // unlock pair first, then the command, so stray writes never alter the array
  function automatic logic [24:0] step_word(input logic [2:0] op, input logic [2:0] k,
                                            input logic [16:0] a, input logic [7:0] d);
    logic [24:0] w;
    w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
    case (k)
      3'h0: w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
      3'h1: w = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
      3'h2: begin
        case (op)
          flash_host_pkg::OP_ID_ENTER: w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::CMD_ID};
          flash_host_pkg::OP_RESET:    w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::CMD_RESET};
          flash_host_pkg::OP_PROGRAM:  w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::CMD_PROGRAM};
          default:                     w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::CMD_ERASE_SET};
        endcase
      end
      3'h3: w = (op == flash_host_pkg::OP_PROGRAM) ? {a, d}
              : {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
      3'h4: w = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
      default: begin
        // sector erase carries the sector on the top three bits
        if (op == flash_host_pkg::OP_SECT_ERASE) begin
          w = {a[16:flash_host_pkg::SECT_LSB], 14'h0000, flash_host_pkg::CMD_SECT_ERASE};
        end else begin
          w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::CMD_CHIP_ERASE};
        end
      end
    endcase
    return w;
  endfunction

  function automatic logic [2:0] last_step(input logic [2:0] op);
    case (op)
      flash_host_pkg::OP_PROGRAM:    return 3'h3;
      flash_host_pkg::OP_CHIP_ERASE: return 3'h5;
      flash_host_pkg::OP_SECT_ERASE: return 3'h5;
      flash_host_pkg::OP_ID_ENTER:   return 3'h2;
      flash_host_pkg::OP_RESET:      return 3'h2;
      default:                       return 3'h0;
    endcase
  endfunction

  function automatic logic is_seq(input logic [2:0] op);
    return (op != flash_host_pkg::OP_READ) && (op != flash_host_pkg::OP_WRITE)
        && (op != flash_host_pkg::OP_ID_HV);
  endfunction

  // ----------------------------------------
  // main sequencer and software registers
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    cy_start = 1'b0;
    cy_write = 1'b0;
    cy_addr  = s_reg.addr; // reads carry the full address, sector bits included
    cy_wdata = s_reg.wdata;
    // read data only in the cycle after the strobe
    s_next.sw_rdata = 32'h0000_0000;
    if (sw_rd_in) begin
      case (sw_addr_in)
        flash_host_pkg::REG_ADDR:   s_next.sw_rdata = {15'h0000, s_reg.addr};
        flash_host_pkg::REG_DATA:   s_next.sw_rdata = {24'h000000, s_reg.wdata};
        flash_host_pkg::REG_STATUS: s_next.sw_rdata = {27'h0000000, s_reg.id_mode, s_reg.err,
                                                       s_reg.done, s_reg.pu_block, s_reg.st != ST_IDLE};
        flash_host_pkg::REG_RDATA:  s_next.sw_rdata = {24'h000000, s_reg.rdata};
        default:                    s_next.sw_rdata = 32'h0000_0000;
      endcase
    end
    if (sw_wr_in && s_reg.st == ST_IDLE) begin
      case (sw_addr_in)
        flash_host_pkg::REG_ADDR: s_next.addr  = sw_wdata_in[16:0];
        flash_host_pkg::REG_DATA: s_next.wdata = sw_wdata_in[7:0];
        // commands held off until software clears the power-up block
        flash_host_pkg::REG_CMD: begin
          if (!s_reg.pu_block) begin
            s_next.op   = sw_wdata_in[2:0];
            s_next.hv   = (sw_wdata_in[2:0] == flash_host_pkg::OP_ID_HV);
            s_next.step = 3'h0;
            s_next.last = last_step(sw_wdata_in[2:0]);
            s_next.err  = 1'b0;
            s_next.st   = ST_ISSUE;
          end
        end
        flash_host_pkg::REG_STATUS: s_next.pu_block = sw_wdata_in[1];
        default: s_next.st = s_reg.st;
      endcase
    end
    case (s_reg.st)
      // a command write above moves on to issue; nothing else to do here
      ST_IDLE: cy_start = 1'b0;
      ST_ISSUE: begin
        cy_start = 1'b1;
        if (is_seq(s_reg.op)) begin
          cy_write = 1'b1;
          {cy_addr, cy_wdata} = step_word(s_reg.op, s_reg.step, s_reg.addr, s_reg.wdata);
        end else begin
          cy_write = (s_reg.op == flash_host_pkg::OP_WRITE);
        end
        s_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (cy_done) begin
          s_next.rdata = cy_rdata;
          if (is_seq(s_reg.op) && s_reg.step != s_reg.last) begin
            s_next.step = s_reg.step + 3'h1;
            s_next.st   = ST_ISSUE;
          end else if (s_reg.op == flash_host_pkg::OP_PROGRAM ||
                       s_reg.op == flash_host_pkg::OP_CHIP_ERASE ||
                       s_reg.op == flash_host_pkg::OP_SECT_ERASE) begin
            s_next.op   = flash_host_pkg::OP_READ;
            s_next.prev = 8'h00;
            s_next.st   = ST_POLL;
          end else begin
            // reset leaves ID mode, ID entry keeps it until reset
            if (s_reg.op == flash_host_pkg::OP_ID_ENTER) s_next.id_mode = 1'b1;
            if (s_reg.op == flash_host_pkg::OP_RESET)    s_next.id_mode = 1'b0;
            s_next.hv   = 1'b0;
            s_next.done = 1'b1;
            s_next.st   = ST_IDLE;
          end
        end
      end
      ST_POLL: begin
        // toggle bit stops toggling when the device is back in array read
        cy_start = !cy_busy && !cy_done;
        if (cy_done) begin
          s_next.prev = cy_rdata;
          if (s_reg.prev[6] == cy_rdata[6] && s_reg.step == 3'h7) begin
            s_next.done = 1'b1;
            s_next.st   = ST_IDLE;
          end else if (cy_rdata[flash_host_pkg::ERR_BIT] && s_reg.step == 3'h7) begin
            // error: host must send reset to regain array read
            s_next.err  = 1'b1;
            s_next.op   = flash_host_pkg::OP_RESET;
            s_next.step = 3'h0;
            s_next.last = last_step(flash_host_pkg::OP_RESET);
            s_next.st   = ST_ISSUE;
          end
          s_next.step = (s_next.st == ST_POLL) ? 3'h7 : s_next.step;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (sys_rst_in) begin
      s_next = '0;
      s_next.pu_block = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    s_reg <= s_next;
  end

  flash_bus_cycle u_cycle (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .start_in       (cy_start),
    .write_in       (cy_write),
    .addr_in        (cy_addr),
    .wdata_in       (cy_wdata),
    .pin_data_in    (data_pins_in),
    .busy_out       (cy_busy),
    .done_out       (cy_done),
    .rdata_out      (cy_rdata),
    .addr_pin_out   (pin_addr),
    .data_pin_out   (pin_wdata),
    .data_oe_out    (pin_oe),
    .chip_sel_n_out (pin_cs_n),
    .out_en_n_out   (pin_oen_n),
    .write_n_out    (pin_we_n)
  );

  // outputs all come from flip-flops in the cycle module or here
  assign sw_rdata_out            = s_reg.sw_rdata;
  assign data_pins_out           = pin_wdata;
  assign data_pins_oe_out        = pin_oe;
  assign addr_pins_out           = pin_addr;
  assign chip_sel_n_out          = pin_cs_n;
  assign out_en_n_out            = pin_oen_n;
  assign write_n_out             = pin_we_n;
  assign elevated_id_voltage_out = s_reg.hv;

  // elevated voltage only with write strobe high
  AST_HV_NO_WRITE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_reg.hv |-> pin_we_n) else $error("write during high-voltage id");
  // every command sequence opens with the first unlock write
  AST_UNLOCK_FIRST: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (s_reg.st == ST_ISSUE && is_seq(s_reg.op) && s_reg.step == 3'h0) |->
    (cy_addr == flash_host_pkg::UNLOCK1_ADDR && cy_wdata == flash_host_pkg::UNLOCK1_DATA))
    else $error("sequence without unlock");
  // power-up block refuses commands
  AST_PU_BLOCK: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (s_reg.pu_block && s_reg.st == ST_IDLE) |=> s_reg.st == ST_IDLE)
    else $error("command during power-up block");
endmodule

// ---- tb/flash_dev_model.sv ----
// behavioural model of the byte-wide sectored flash device
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h4d, // arbitrary value
  parameter int         BUSY_READS = 3
) (
  input  wire logic        cs_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [16:0] addr_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic [7:0]  prot_in,
  input  wire logic        lowv_in,
  input  wire logic        hv_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe_out
);
  logic [7:0]  mem [0:131071];
  logic [16:0] la;
  logic [2:0]  step;
  logic        id_mode;
  logic        err;
  logic        tog;
  int          busy;
  int          wr_cnt;
  realtime     t_sel;
  wire         wsel = ~cs_n_in & ~we_n_in & oe_n_in;
  wire         rsel = ~cs_n_in & ~oe_n_in & we_n_in;
  // power-up: array read, all sectors open
  initial begin
    for (int i = 0; i < 131072; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    step = 3'd0;
    {id_mode, err, tog, busy, wr_cnt} = '0;
  end
  // -----------------------------------------
  // write decode
  // -----------------------------------------
  // program or erase; protected sectors untouched
  task automatic start(input logic [16:0] a, input logic [7:0] d);
    busy = BUSY_READS;
    if (step == 3'd3) begin
      if (prot_in[a[16:14]]) return;
      err = |(d & ~mem[a]); // a cleared bit cannot come back
      mem[a] = mem[a] & d;
    end else
      for (int i = 0; i < 131072; i++)
        if (!prot_in[i[16:14]] && (d == 8'h10 || i[16:14] == a[16:14])) mem[i] = 8'hff;
  endtask
  task automatic cmd(input logic [16:0] a, input logic [7:0] d);
    logic ok;
    if (busy > 0 && !err) return;
    wr_cnt++;
    if (step == 3'd2 && a[14:0] == 15'h5555 && d == 8'hf0) begin
      {id_mode, err, busy, step} = '0;
      return;
    end
    case (step)
      3'd0, 3'd4: ok = a[14:0] == 15'h5555 && d == 8'haa;
      3'd1, 3'd5: ok = a[14:0] == 15'h2aaa && d == 8'h55;
      3'd2: ok = a[14:0] == 15'h5555 && (d == 8'h90 || d == 8'ha0 || d == 8'h80);
      3'd3: ok = 1'b1;
      default: ok = (a[14:0] == 15'h5555 && d == 8'h10) || d == 8'h30;
    endcase
    if (!ok) begin
      step = 3'd0;
      return;
    end
    id_mode = id_mode | (step == 3'd2 && d == 8'h90);
    if (step == 3'd3 || step == 3'd6) begin
      start(a, d);
      step = 3'd0;
    end else
      step = step == 3'd2 ? (d == 8'h90 ? 3'd0 : d == 8'h80 ? 3'd4 : 3'd3) : step + 3'd1;
  endtask
  // address on later falling edge, data on earlier rising edge
  always @(posedge wsel) begin
    la    = addr_in;
    t_sel = $realtime;
  end
  always @(negedge wsel) begin
    if (lowv_in)
      {id_mode, step} = '0;
    else if ($realtime - t_sel >= 5.0) // short glitches start no write
      cmd(la, dq_in);
  end
  // -----------------------------------------
  // read side
  // -----------------------------------------
  // status while working, codes in id mode, else array
  always @(posedge rsel) begin
    tog = ~tog;
    if (busy > 0)
      dq_out = {1'b0, tog, err, 5'h00};
    else if (hv_in || id_mode)
      dq_out = addr_in[1:0] == 2'd0 ? MAKER_CODE : addr_in[1:0] == 2'd1 ? PART_CODE :
               {7'h00, prot_in[addr_in[16:14]]};
    else
      dq_out = mem[addr_in];
    if (busy > 0 && !err) busy--;
  end
  assign dq_oe_out = rsel;
endmodule

// ---- tb/flash_host_ctrl_tb.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_host_ctrl_tb;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] PART  = 8'h4d; // arbitrary value
  logic        clock_in, sys_rst_in, sw_wr, sw_rd, rd_d, dq_oe, ctl_oe, cs_n, oe_n, we_n, hv, lowv;
  logic [3:0]  sw_addr;
  logic [31:0] sw_wdata, rdata;
  logic [7:0]  dq, dq_dev, dq_ctl, dq_hold, prot, d;
  logic [16:0] apin, a;
  logic [63:0] q [$];
  int          errors, checks_done, seed, n0;
  int          cyc = 0;
  flash_host_ctrl DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(rdata),
    .data_pins_in(dq), .data_pins_out(dq_ctl), .data_pins_oe_out(ctl_oe), .addr_pins_out(apin),
    .chip_sel_n_out(cs_n), .out_en_n_out(oe_n), .write_n_out(we_n), .elevated_id_voltage_out(hv));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash (.cs_n_in(cs_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .addr_in(apin), .dq_in(dq), .prot_in(prot), .lowv_in(lowv), .hv_in(hv),
    .dq_out(dq_dev), .dq_oe_out(dq_oe));
  // released bus shows the inverse of its last level
  always_comb dq = dq_oe ? dq_dev : ctl_oe ? dq_ctl : ~dq_hold;
  always @(posedge clock_in) if (dq_oe || ctl_oe) dq_hold <= dq;
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // -----------------------------------------
  // checking
  // -----------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // note is {mask, expected}; an empty mask is a poll
  task automatic chk(input logic [63:0] e, input logic [31:0] g);
    if (e[63:32] == 32'h0) return;
    checks_done++;
    if ((g & e[63:32]) !== e[31:0]) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e[31:0]);
    end
  endtask
  // oldest note meets each read result; also hang guard
  always @(posedge clock_in) begin
    rd_d <= sw_rd;
    cyc  <= cyc + 1;
    if (rd_d && q.size() > 0) chk(q.pop_front(), rdata);
    if (cyc == 60000) begin
      errors++;
      close_out();
    end
  end
  // -----------------------------------------
  // register port tasks
  // -----------------------------------------
  task automatic wr(input logic [3:0] r, input logic [31:0] v);
    @(posedge clock_in);
    sw_addr  <= r;
    sw_wdata <= v;
    sw_wr    <= 1'b1;
    @(posedge clock_in);
    sw_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] r, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock_in);
    sw_addr <= r;
    sw_rd   <= 1'b1;
    q.push_back({m, e});
    @(posedge clock_in);
    sw_rd   <= 1'b0;
    #1;
  endtask
  // issue a command, poll busy with a bound
  task automatic op(input logic [2:0] c, input logic [16:0] ad);
    wr(flash_host_pkg::REG_ADDR, {15'h0, ad});
    wr(flash_host_pkg::REG_CMD, {29'h0, c});
    repeat (400) begin
      rd(flash_host_pkg::REG_STATUS, 32'h0, 32'h0);
      if (rdata[0] === 1'b0) break;
    end
  endtask
  task automatic rda(input logic [2:0] c, input logic [16:0] ad, input logic [7:0] e);
    op(c, ad);
    rd(flash_host_pkg::REG_RDATA, {24'h0, e}, 32'hff);
  endtask
  task automatic prog(input logic [16:0] ad, input logic [7:0] v);
    wr(flash_host_pkg::REG_DATA, {24'h0, v});
    op(flash_host_pkg::OP_PROGRAM, ad);
  endtask
  function automatic logic [7:0] pat(input logic [16:0] x);
    return x[7:0] ^ 8'h5a;
  endfunction
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  initial begin
    {sys_rst_in, sw_wr, sw_rd, sw_addr, sw_wdata, prot, lowv} = {1'b1, 47'h0};
    {errors, checks_done} = '0;
    seed = 59;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(flash_host_pkg::REG_STATUS, 32'h2, 32'h1f);
    wr(flash_host_pkg::REG_CMD, {29'h0, flash_host_pkg::OP_PROGRAM});
    repeat (30) @(posedge clock_in);
    chk({32'hffffffff, 32'h0}, 32'(flash.wr_cnt));
    wr(flash_host_pkg::REG_STATUS, 32'h0);
    rda(flash_host_pkg::OP_READ, 17'h1c0ff, pat(17'h1c0ff));
    // random byte in sector 0, clearing bits only
    a = 17'($random(seed)) & 17'h00fff;
    d = pat(a) & 8'($random(seed));
    prog(a, d);
    chk({32'hffffffff, 32'h4}, 32'(flash.wr_cnt));
    rda(flash_host_pkg::OP_READ, a, d);
    n0 = flash.wr_cnt;
    wr(flash_host_pkg::REG_DATA, 32'h37);
    op(flash_host_pkg::OP_WRITE, 17'h01234);
    chk({32'hffffffff, 32'(n0 + 1)}, 32'(flash.wr_cnt));
    prot = 8'h04;
    prog(17'h08010, 8'h00);
    rda(flash_host_pkg::OP_READ, 17'h08010, pat(17'h08010));
    prot = 8'h00;
    prog(17'h08010, 8'h00);
    rda(flash_host_pkg::OP_READ, 17'h08010, 8'h00);
    prog(17'h08010, 8'hff);
    rd(flash_host_pkg::REG_STATUS, 32'h8, 32'h9);
    rda(flash_host_pkg::OP_READ, 17'h08010, 8'h00);
    prot = 8'h20;
    op(flash_host_pkg::OP_SECT_ERASE, 17'h04000);
    rda(flash_host_pkg::OP_READ, 17'h04123, 8'hff);
    rda(flash_host_pkg::OP_READ, 17'h03123, pat(17'h03123));
    op(flash_host_pkg::OP_CHIP_ERASE, 17'h00000);
    rda(flash_host_pkg::OP_READ, 17'h03123, 8'hff);
    rda(flash_host_pkg::OP_READ, 17'h14123, pat(17'h14123));
    // low supply: the id sequence must not reach the command logic
    n0 = flash.wr_cnt;
    lowv = 1'b1;
    op(flash_host_pkg::OP_ID_ENTER, 17'h00000);
    lowv = 1'b0;
    chk({32'hffffffff, 32'(n0)}, 32'(flash.wr_cnt));
    rda(flash_host_pkg::OP_READ, 17'h14002, pat(17'h14002));
    prot = 8'h08;
    op(flash_host_pkg::OP_ID_ENTER, 17'h00000);
    rd(flash_host_pkg::REG_STATUS, 32'h10, 32'h11);
    rda(flash_host_pkg::OP_READ, 17'h00000, MAKER);
    rda(flash_host_pkg::OP_READ, 17'h1c001, PART);
    rda(flash_host_pkg::OP_READ, 17'h0c002, 8'h01);
    rda(flash_host_pkg::OP_READ, 17'h10002, 8'h00);
    op(flash_host_pkg::OP_RESET, 17'h00000);
    rd(flash_host_pkg::REG_STATUS, 32'h0, 32'h10);
    rda(flash_host_pkg::OP_READ, 17'h14001, pat(17'h14001));
    rda(flash_host_pkg::OP_ID_HV, 17'h00000, MAKER);
    rda(flash_host_pkg::OP_ID_HV, 17'h00001, PART);
    rda(flash_host_pkg::OP_ID_HV, 17'h0c002, 8'h01);
    rda(flash_host_pkg::OP_ID_HV, 17'h04002, 8'h00);
    rd(4'hf, 32'h0, 32'hffffffff);
    repeat (4) @(posedge clock_in);
    close_out();
  end
endmodule
